// *** rtl/arc_cal_seq.sv ***
// converter reset, calibration, clock divider and output latency sequencer
// assumes an apb master on clk_in; pins arrive asynchronously
// How it works
// R1 - each sample appears on the outputs seven and a half sample clocks after capture
// R2 - calibration starts when the calibration reset rises
// R3 - over-range flag forced high from reset low until calibration ends
// R4 - sample clock held low during reset, restarts on next edge after release
// R5 - calibration takes the nominal time; host allows up to the maximum
// R6 - a reset low for one cycle or more always recalibrates
// R7 - power-on detector releases reset, which starts calibration automatically
// R8 - host sends no serial transactions during power-on calibration
// R9 - host keeps the conversion clock frequency stable during calibration
// R10 - host keeps the serial data line high during power-up
// R11 - external logic lets the reset line start low at power-up
// R12 - host sets pins as for power-on before a recalibration
// R13 - tri-level select pin: ground divides by 2, float by 1, supply by 4
// R14 - a divider setting written by software overrides the select pin
// R15 - after a clock frequency change the loop relocks within 52 us
// R16 - host sees completion as over-range falling, timeout at maximum time
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "arc_defs.svh"
module arc_cal_seq #(
   parameter logic [24:0] CAL_CYCLES = 25'(`ARC_CAL_CYC)
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic por_ok_in,
   input wire logic calib_reset_low_in,
   input wire logic [1:0] divider_select_pin_in,
   input wire logic [11:0] sample_data_in,
   output logic sample_clock_out,
   output logic [11:0] data_out,
   output logic over_range_out,
   output logic irq_out,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] por_sync_reg;
   logic [1:0] rst_sync_reg;
   logic [1:0] sel_meta_reg;
   logic [1:0] sel_sync_reg;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         por_sync_reg <= 2'h0;
         rst_sync_reg <= 2'h0;
         sel_meta_reg <= `ARC_DIVSEL_FLOAT;
         sel_sync_reg <= `ARC_DIVSEL_FLOAT;
      end else begin
         por_sync_reg <= {por_sync_reg[0], por_ok_in};
         rst_sync_reg <= {rst_sync_reg[0], calib_reset_low_in};
         sel_meta_reg <= divider_select_pin_in;
         sel_sync_reg <= sel_meta_reg;
      end
   end

   // ----------------------------------------
   // registers and wires
   // ----------------------------------------
   arc_pkg::arc_state_t state_reg;
   logic [24:0] cal_cnt_reg;
   logic soft_low_reg;
   logic eff_low;
   logic ovr_en_reg;
   logic [1:0] ovr_code_reg;
   logic [1:0] code_next;
   logic [2:0] half_next;
   logic [2:0] half_reg;
   logic [11:0] relock_cnt_reg;
   logic locked_reg;
   logic [11:0] pipe_reg [`ARC_PIPE_DEPTH];
   logic [11:0] data_reg;
   logic or_reg;
   logic [`ARC_IRQ_W-1:0] irq_stat_reg;
   logic [`ARC_IRQ_W-1:0] irq_mask_reg;
   logic [`ARC_IRQ_W-1:0] irq_set;
   logic [31:0] prdata_reg;
   logic wr_en;
   logic mapped;
   logic cal_start;
   logic cal_done;
   logic relock_done;

   arc_clk_if ck ();

   arc_clk_div u_div (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .ck(ck)
   );

   // ----------------------------------------
   // calibration sequence
   // ----------------------------------------
   // the pin low, the power-on detector not yet released, or a software pulse
   assign eff_low = !rst_sync_reg[1] || !por_sync_reg[1] || soft_low_reg; // R7 R6
   assign cal_start = (state_reg == arc_pkg::ARC_ST_HELD) && !eff_low; // R2
   assign cal_done = (state_reg == arc_pkg::ARC_ST_CAL) && !eff_low && (cal_cnt_reg == CAL_CYCLES - 25'h1);

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_reg <= arc_pkg::ARC_ST_HELD;
      end else begin
         case (state_reg)
            arc_pkg::ARC_ST_HELD: begin
               if (!eff_low) begin
                  state_reg <= arc_pkg::ARC_ST_CAL; // R2
               end
            end
            arc_pkg::ARC_ST_CAL: begin
               if (eff_low) begin
                  state_reg <= arc_pkg::ARC_ST_HELD; // R6
               end else if (cal_done) begin
                  state_reg <= arc_pkg::ARC_ST_RUN; // R5
               end
            end
            arc_pkg::ARC_ST_RUN: begin
               if (eff_low) begin
                  state_reg <= arc_pkg::ARC_ST_HELD; // R6
               end
            end
            default: begin
               state_reg <= arc_pkg::ARC_ST_HELD;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cal_cnt_reg <= 25'h0;
      end else if (state_reg != arc_pkg::ARC_ST_CAL) begin
         cal_cnt_reg <= 25'h0;
      end else begin
         cal_cnt_reg <= cal_cnt_reg + 25'h1; // R5
      end
   end

   // ----------------------------------------
   // divider selection and loop relock
   // ----------------------------------------
   assign code_next = ovr_en_reg ? ovr_code_reg : sel_sync_reg; // R14

   always_comb begin
      case (code_next)
         `ARC_DIVSEL_GND: half_next = `ARC_HALF_DIV2; // R13
         `ARC_DIVSEL_SUPPLY: half_next = `ARC_HALF_DIV4; // R13
         default: half_next = `ARC_HALF_DIV1; // R13
      endcase
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         half_reg <= `ARC_HALF_DIV1;
      end else begin
         half_reg <= half_next;
      end
   end

   // a ratio change restarts the relock wait; samples still flow meanwhile
   assign relock_done = !locked_reg && (relock_cnt_reg == 12'h1);

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         relock_cnt_reg <= 12'h0;
         locked_reg <= 1'b1;
      end else if (half_next != half_reg) begin
         relock_cnt_reg <= 12'(`ARC_RELOCK_CYC); // R15
         locked_reg <= 1'b0;
      end else if (relock_cnt_reg != 12'h0) begin
         relock_cnt_reg <= relock_cnt_reg - 12'h1;
         locked_reg <= (relock_cnt_reg == 12'h1);
      end
   end

   assign ck.half = half_reg;
   assign ck.hold = state_reg == arc_pkg::ARC_ST_HELD; // R4
   assign sample_clock_out = ck.sclk;

   // ----------------------------------------
   // sample pipeline
   // ----------------------------------------
   // captured on the rising sample edge, launched on the falling one
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         for (int i = 0; i < `ARC_PIPE_DEPTH; i++) begin
            pipe_reg[i] <= 12'h000;
         end
      end else if (ck.rise_tick) begin
         pipe_reg[0] <= sample_data_in; // R1
         for (int i = 1; i < `ARC_PIPE_DEPTH; i++) begin
            pipe_reg[i] <= pipe_reg[i-1]; // R1
         end
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         data_reg <= 12'h000;
      end else if (ck.fall_tick) begin
         data_reg <= pipe_reg[`ARC_PIPE_DEPTH-1]; // R1
      end
   end

   // flag is forced until run; afterwards it tracks full scale per sample
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         or_reg <= 1'b1;
      end else if (eff_low || state_reg != arc_pkg::ARC_ST_RUN) begin
         or_reg <= 1'b1; // R3
      end else if (ck.fall_tick) begin
         or_reg <= pipe_reg[`ARC_PIPE_DEPTH-1] == `ARC_FULL_SCALE; // R3
      end
   end

   assign data_out = data_reg;
   assign over_range_out = or_reg;

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   assign mapped = (paddr == `ARC_OFF_CTRL) || (paddr == `ARC_OFF_STATUS) ||
                   (paddr == `ARC_OFF_IRQ_STAT) || (paddr == `ARC_OFF_IRQ_MASK);
   assign wr_en = psel && penable && pwrite && mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_reg;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         ovr_en_reg <= 1'b0;
         ovr_code_reg <= `ARC_DIVSEL_FLOAT;
      end else if (wr_en && paddr == `ARC_OFF_CTRL) begin
         ovr_en_reg <= pwdata[`ARC_CTRL_OVR_BIT]; // R14
         ovr_code_reg <= pwdata[`ARC_CTRL_CODE_LSB +: 2];
      end
   end

   // a one-cycle internal low is enough to recalibrate
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         soft_low_reg <= 1'b0;
      end else begin
         soft_low_reg <= wr_en && paddr == `ARC_OFF_CTRL && pwdata[`ARC_CTRL_RECAL_BIT]; // R6
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         irq_mask_reg <= '0;
      end else if (wr_en && paddr == `ARC_OFF_IRQ_MASK) begin
         irq_mask_reg <= pwdata[`ARC_IRQ_W-1:0];
      end
   end

   // read data is latched in setup so it stands through the access phase
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         prdata_reg <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (paddr)
            `ARC_OFF_CTRL: prdata_reg <= {28'h0, 1'b0, ovr_code_reg, ovr_en_reg};
            `ARC_OFF_STATUS: prdata_reg <= {27'h0, code_next, locked_reg, state_reg};
            `ARC_OFF_IRQ_STAT: prdata_reg <= {29'h0, irq_stat_reg};
            `ARC_OFF_IRQ_MASK: prdata_reg <= {29'h0, irq_mask_reg};
            default: prdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   assign irq_set = {relock_done, cal_done, cal_start};

   // a set in the clearing cycle wins
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         irq_stat_reg <= '0;
      end else if (wr_en && paddr == `ARC_OFF_IRQ_STAT) begin
         irq_stat_reg <= (irq_stat_reg & ~pwdata[`ARC_IRQ_W-1:0]) | irq_set;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_set;
      end
   end

   assign irq_out = |(irq_stat_reg & irq_mask_reg);

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   sequence s_held_release;
      state_reg == arc_pkg::ARC_ST_HELD && !eff_low;
   endsequence

   sequence s_cal_entered;
      state_reg == arc_pkg::ARC_ST_CAL && cal_cnt_reg == 25'h0;
   endsequence

   AST_LATENCY: assert property (ck.fall_tick |=> data_out == $past(pipe_reg[`ARC_PIPE_DEPTH-1])) // R1
      else $error("data not launched from last pipeline stage");
   AST_SHIFT: assert property (ck.rise_tick |=> pipe_reg[1] == $past(pipe_reg[0])) // R1
      else $error("pipeline did not shift on sample edge");
   AST_CAL_START: assert property (s_held_release |=> s_cal_entered) // R2
      else $error("calibration did not start on release");
   AST_OR_FORCED: assert property (state_reg != arc_pkg::ARC_ST_RUN |=> over_range_out) // R3
      else $error("over-range low before calibration done");
   AST_CLK_LOW: assert property (ck.hold |=> !sample_clock_out) // R4
      else $error("sample clock not held low");
   AST_CLK_RESTART: assert property ($fell(ck.hold) |-> ck.rise_tick ##1 sample_clock_out) // R4
      else $error("sample clock did not restart at once");
   AST_CAL_LEN: assert property (state_reg == arc_pkg::ARC_ST_CAL |-> cal_cnt_reg < CAL_CYCLES) // R5
      else $error("calibration overran its length");
   AST_CAL_END: assert property (cal_done |=> state_reg == arc_pkg::ARC_ST_RUN ##1 1'b1) // R5
      else $error("calibration did not end on time");
   AST_RECAL: assert property (eff_low |=> state_reg == arc_pkg::ARC_ST_HELD) // R6
      else $error("low reset did not restart calibration");
   AST_POR: assert property (!por_sync_reg[1] |=> state_reg == arc_pkg::ARC_ST_HELD) // R7
      else $error("left hold before power-on release");
   AST_DIV_GND: assert property (!ovr_en_reg && sel_sync_reg == `ARC_DIVSEL_GND |=> half_reg == `ARC_HALF_DIV2) // R13
      else $error("ground select not divide by two");
   AST_OVERRIDE: assert property (ovr_en_reg && ovr_code_reg == `ARC_DIVSEL_SUPPLY |=> half_reg == `ARC_HALF_DIV4) // R14
      else $error("software divider setting ignored");
   AST_RELOCK: assert property (half_next != half_reg |=> !locked_reg [*2]) // R15
      else $error("lock reported right after ratio change");
endmodule : arc_cal_seq

// *** rtl/arc_defs.svh ***
// constants of the reset and calibration sequencer
// assumes one 50 MHz core clock and an apb register bus
`ifndef ARC_DEFS_SVH
`define ARC_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define ARC_CLK_HZ 50000000
`define ARC_CAL_NOM_MS 200
`define ARC_CAL_MAX_MS 550
`define ARC_CAL_CYC ((`ARC_CAL_NOM_MS) * (`ARC_CLK_HZ / 1000))
`define ARC_RELOCK_US 52
`define ARC_RELOCK_CYC ((`ARC_RELOCK_US) * (`ARC_CLK_HZ / 1000000))
`define ARC_PIPE_DEPTH 8
`define ARC_FULL_SCALE 12'hFFF

// ----------------------------------------
// tri-level divider select codes and half periods
// ----------------------------------------
`define ARC_DIVSEL_GND 2'h0
`define ARC_DIVSEL_FLOAT 2'h1
`define ARC_DIVSEL_SUPPLY 2'h2
`define ARC_HALF_DIV1 3'h1
`define ARC_HALF_DIV2 3'h2
`define ARC_HALF_DIV4 3'h4

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define ARC_OFF_CTRL 8'h00
`define ARC_OFF_STATUS 8'h04
`define ARC_OFF_IRQ_STAT 8'h08
`define ARC_OFF_IRQ_MASK 8'h0C
`define ARC_CTRL_OVR_BIT 0
`define ARC_CTRL_CODE_LSB 1
`define ARC_CTRL_RECAL_BIT 3
`define ARC_IRQ_CAL_START 0
`define ARC_IRQ_CAL_DONE 1
`define ARC_IRQ_RELOCK 2
`define ARC_IRQ_W 3

`endif

// *** rtl/arc_pkg.sv ***
// types of the reset and calibration sequencer
// assumes the constants header is included where numbers are needed
package arc_pkg;
   typedef enum logic [1:0] {
      ARC_ST_HELD = 2'b00,
      ARC_ST_CAL = 2'b01,
      ARC_ST_RUN = 2'b10
   } arc_state_t;
endpackage : arc_pkg

// *** rtl/arc_clk_if.sv ***
// signals between the sequencer and its sample clock divider
// assumes both ends run on the core clock
`timescale 1ns/10ps
interface arc_clk_if;
   logic [2:0] half;
   logic hold;
   logic rise_tick;
   logic fall_tick;
   logic sclk;
   modport gen (input half, input hold, output rise_tick, output fall_tick, output sclk);
   modport use_end (output half, output hold, input rise_tick, input fall_tick, input sclk);
endinterface : arc_clk_if

// *** rtl/arc_clk_div.sv ***
// sample clock divider: period of two half periods of core cycles
// assumes half is 1, 2 or 4 and hold is synchronous to clk_in
`timescale 1ns/10ps
`include "arc_defs.svh"
module arc_clk_div (
   input wire logic clk_in,
   input wire logic reset_in,
   arc_clk_if.gen ck
);
   logic [3:0] phase_reg;
   logic [3:0] last;
   logic sclk_reg;

   assign last = {ck.half, 1'b0} - 4'h1;
   assign ck.rise_tick = !ck.hold && (phase_reg == 4'h0);
   assign ck.fall_tick = !ck.hold && (phase_reg == {1'b0, ck.half});
   assign ck.sclk = sclk_reg;

   // restarting at phase zero makes the first edge after release a rising one
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         phase_reg <= 4'h0;
      end else if (ck.hold || phase_reg >= last) begin
         phase_reg <= 4'h0;
      end else begin
         phase_reg <= phase_reg + 4'h1;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sclk_reg <= 1'b0;
      end else if (ck.hold) begin
         sclk_reg <= 1'b0; // R4
      end else if (ck.rise_tick) begin
         sclk_reg <= 1'b1; // R4
      end else if (ck.fall_tick) begin
         sclk_reg <= 1'b0;
      end
   end
endmodule : arc_clk_div

// *** dv/arc_host_model.sv ***
// host-side model driving the calibration reset pin and timing calibration
// assumes the pin has a pull-up, so a released pin reads high
`timescale 1ns/10ps
module arc_host_model #(
   parameter int TIMEOUT_CYC = 137
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic go_in,
   input wire logic [15:0] low_cycles_in,
   input wire logic over_range_in,
   output logic calib_reset_low_out,
   output logic cal_done_out,
   output logic cal_timeout_out
);
   logic [15:0] left_reg;
   logic [1:0] phase_reg;
   int wait_reg;
   // ----------------------------------------
   // pin drive
   // ----------------------------------------
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         calib_reset_low_out <= 1'b0;
         left_reg <= 16'h0000;
      end else if (go_in) begin
         calib_reset_low_out <= 1'b0;
         left_reg <= low_cycles_in;
      end else if (left_reg > 16'h0001) begin
         left_reg <= left_reg - 16'h0001;
      end else if (left_reg == 16'h0001) begin
         calib_reset_low_out <= 1'b1;
         left_reg <= 16'h0000;
      end
   end
   // ----------------------------------------
   // completion watch
   // ----------------------------------------
   // waits for the flag high first, a stale low would fake completion
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         phase_reg <= 2'h0;
         wait_reg <= 0;
         cal_done_out <= 1'b0;
         cal_timeout_out <= 1'b0;
      end else if (go_in) begin
         phase_reg <= 2'h1;
         wait_reg <= 0;
         cal_done_out <= 1'b0;
         cal_timeout_out <= 1'b0;
      end else if (phase_reg != 2'h0 && left_reg == 16'h0000) begin
         wait_reg <= wait_reg + 1;
         if (over_range_in) begin
            phase_reg <= 2'h2;
         end else if (phase_reg == 2'h2) begin
            cal_done_out <= 1'b1;
            phase_reg <= 2'h0;
         end
         if (wait_reg >= TIMEOUT_CYC) begin
            cal_timeout_out <= 1'b1;
            phase_reg <= 2'h0;
         end
      end
   end
endmodule : arc_host_model

// *** dv/tb_arc_cal_seq.sv ***
// self-checking testbench of the reset and calibration sequencer
// assumes a host model on the reset pin; registers reached over apb
`timescale 1ns/10ps
`include "arc_defs.svh"
module tb_arc_cal_seq;
   localparam int CAL = 50;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic por_ok_in = 1'b0;
   logic [1:0] div_pin = 2'h1;
   logic fs = 1'b0;
   logic go = 1'b0;
   logic [15:0] low_len = 16'h0001;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic [11:0] data_out;
   logic pready, pslverr, err, sclk, ovr, irq, cal_low, h_done, h_tout;
   int cyc = 0;
   int error_cnt = 0;
   int checks_done = 0;
   int c;
   arc_cal_seq #(.CAL_CYCLES(25'(CAL))) arc_cal_seq_inst (.clk_in(clk_in), .reset_in(reset_in),
      .por_ok_in(por_ok_in), .calib_reset_low_in(cal_low), .divider_select_pin_in(div_pin),
      .sample_data_in(fs ? 12'hFFF : {1'b0, cyc[10:0]}), .sample_clock_out(sclk), .data_out(data_out),
      .over_range_out(ovr), .irq_out(irq), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   arc_host_model #(.TIMEOUT_CYC(CAL * 55 / 20)) arc_host_model_inst (.clk_in(clk_in), .reset_in(reset_in),
      .go_in(go), .low_cycles_in(low_len), .over_range_in(ovr), .calib_reset_low_out(cal_low),
      .cal_done_out(h_done), .cal_timeout_out(h_tout));
   initial forever #10 clk_in = ~clk_in;
   always @(posedge clk_in) cyc <= cyc + 1;
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task end_of_test();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task hang(input string n);
      error_cnt++;
      $display("mismatch %s expected done seen timeout", n);
      end_of_test();
   endtask : hang
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_in);
         if (pready === 1'b1) break;
      end
      if (i == 20) hang("pready");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task tick();
      @(posedge clk_in);
      #1;
   endtask : tick
   task wait_or(input logic v);
      for (c = 0; c < 300 && ovr !== v; c++) @(posedge clk_in);
      if (c == 300) hang("over_range");
   endtask : wait_or
   task pulse(input int len);
      @(posedge clk_in);
      low_len <= 16'(len);
      go <= 1'b1;
      @(posedge clk_in);
      go <= 1'b0;
   endtask : pulse
   task rise();
      int i;
      for (i = 0; i < 20 && sclk !== 1'b0; i++) tick();
      for (i = 0; i < 20 && sclk !== 1'b1; i++) tick();
      if (i == 20) hang("sample clock");
   endtask : rise
   // period and sample latency at a given half period
   task measure(input int half);
      int t, d;
      logic [11:0] prev;
      rise();
      t = cyc;
      rise();
      chk("sample clock period", 2 * half, cyc - t);
      repeat (2) begin
         prev = data_out;
         for (d = 0; d < 100 && data_out === prev; d++) tick();
      end
      d = (cyc - int'(data_out)) & 2047;
      chk("latency in window", 1, d >= 15 * half && d <= 15 * half + 2);
   endtask : measure
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_power_on();
      @(posedge clk_in);
      por_ok_in <= 1'b1;
      pulse(1);
      wait_or(1'b0);
      chk("calibration time", 1, c >= CAL && c <= CAL + 30);
      @(posedge clk_in);
      chk("host saw done", 2'b10, {h_done, h_tout});
      apb(1'b0, `ARC_OFF_IRQ_STAT, 32'h0);
      chk("cal events", 2'b11, rd[1:0]);
      $display("test power_on done");
   endtask : t_power_on
   task t_recal();
      pulse(12);
      repeat (5) @(posedge clk_in);
      chk("flag during reset", 1'b1, ovr);
      repeat (4) tick();
      chk("sample clock held", 1'b0, sclk);
      for (c = 0; c < 30 && cal_low !== 1'b1; c++) tick();
      for (c = 0; c < 20 && sclk !== 1'b1; c++) tick();
      chk("clock restart", 1, c <= 6);
      chk("flag during cal", 1'b1, ovr);
      wait_or(1'b0);
      chk("cal after rise", 1, c >= CAL - 6);
      pulse(1);
      repeat (6) @(posedge clk_in);
      apb(1'b0, `ARC_OFF_STATUS, 32'h0);
      chk("short pulse recal", 2'h1, rd[1:0]);
      wait_or(1'b0);
      apb(1'b1, `ARC_OFF_CTRL, 32'h8);
      apb(1'b0, `ARC_OFF_CTRL, 32'h0);
      chk("recal bit reads 0", 1'b0, rd[3]);
      apb(1'b0, `ARC_OFF_STATUS, 32'h0);
      chk("soft recal", 2'h1, rd[1:0]);
      wait_or(1'b0);
      fs <= 1'b1;
      repeat (40) @(posedge clk_in);
      chk("full scale flag", 1'b1, ovr);
      fs <= 1'b0;
      repeat (40) @(posedge clk_in);
      chk("flag normal", 1'b0, ovr);
      $display("test recal done");
   endtask : t_recal
   task t_divider();
      logic [1:0] code [3];
      int half [3];
      int t;
      code = '{2'h0, 2'h1, 2'h2};
      half = '{2, 1, 4};
      div_pin <= 2'h0;
      t = cyc;
      repeat (8) @(posedge clk_in);
      rd = 32'h0;
      for (c = 0; c < 2000 && rd[2] !== 1'b1; c++) apb(1'b0, `ARC_OFF_STATUS, 32'h0);
      chk("relock time", 1, cyc - t >= 2580 && cyc - t <= 2640);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_in);
         div_pin <= code[k];
         repeat (80) @(posedge clk_in);
         measure(half[k]);
      end
      @(posedge clk_in);
      div_pin <= 2'h1;
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, `ARC_OFF_CTRL, {29'h0, code[k], 1'b1});
         repeat (80) @(posedge clk_in);
         measure(half[k]);
         apb(1'b0, `ARC_OFF_STATUS, 32'h0);
         chk("active code", code[k], rd[4:3]);
      end
      apb(1'b1, `ARC_OFF_CTRL, 32'h0);
      $display("test divider done");
   endtask : t_divider
   task t_irq();
      apb(1'b1, `ARC_OFF_IRQ_MASK, 32'h0);
      chk("irq masked", 1'b0, irq);
      apb(1'b1, `ARC_OFF_IRQ_MASK, 32'h2);
      @(posedge clk_in);
      chk("irq raised", 1'b1, irq);
      apb(1'b1, `ARC_OFF_IRQ_STAT, 32'h2);
      @(posedge clk_in);
      chk("irq cleared", 1'b0, irq);
      apb(1'b0, `ARC_OFF_IRQ_MASK, 32'h0);
      chk("mask readback", 32'h2, rd);
      apb(1'b1, `ARC_OFF_IRQ_STAT, 32'h7);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped error", 1'b1, err);
      chk("unmapped read", 32'h0, rd);
      apb(1'b0, `ARC_OFF_IRQ_STAT, 32'h0);
      chk("clear all error", 1'b0, err);
      chk("clear all", 32'h0, rd);
      $display("test irq done");
   endtask : t_irq
   initial begin
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      chk("flag in held", 1'b1, ovr);
      t_power_on();
      t_recal();
      t_divider();
      t_irq();
      end_of_test();
   end
endmodule : tb_arc_cal_seq
